// [src/cwd_ahb_slave.sv]
`timescale 1ns/100ps
module cwd_ahb_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  output logic [7:0] reg_addr,
  output logic reg_mapped,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic acc;
  logic [7:0] addr_q;
  logic map_q;
  logic wr_q;
  logic rd_q;
  logic ready_q;
  logic resp_q;
  logic [31:0] rdata_q;

  // Address phase taken on NONSEQ or SEQ while the bus is ready
  assign acc = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      map_q <= 1'b0;
    end else if (acc) begin
      addr_q <= haddr[7:0];
      map_q <= (haddr[31:8] == 24'h000000);
    end
  end

  // Only whole-word writes land; narrower ones complete but store nothing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= acc & hwrite & (hsize == cwd_pkg::HSIZE_WORD);
      rd_q <= acc & ~hwrite;
    end
  end

  // One wait state on reads so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ~(acc & ~hwrite);
    end
  end

  // Read data captured at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (rd_q) begin
      rdata_q <= reg_rdata;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= 1'b0;
    end
  end

  assign hreadyout = ready_q;
  assign hresp = resp_q;
  assign hrdata = rdata_q;
  assign reg_addr = addr_q;
  assign reg_mapped = map_q;
  assign reg_wr = wr_q;
  assign reg_rd = rd_q;
endmodule

// [src/cwd_nvm_store.sv]
`timescale 1ns/100ps
module cwd_nvm_store (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic por_n,
  // Programming strobe
  input wire logic prog,
  input wire logic [15:0] prog_data,
  // Stored state
  output logic [15:0] word,
  output logic programmed,
  output logic refused
);
  logic [15:0] word_q;
  logic done_q;
  logic refused_q;

  // Cells start erased; one program pass can only clear bits
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      word_q <= cwd_pkg::CW_LOW_ERASED;
      done_q <= 1'b0;
    end else if (prog && !done_q) begin
      word_q <= word_q & prog_data;
      done_q <= 1'b1;
    end
  end

  // Second attempt is dropped and reported for one cycle
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= prog & done_q;
    end
  end

  prog_once_a: assert property (@(posedge hclk) disable iff (!por_n)
    done_q && prog |=> $stable(word_q) && refused_q)
    else $error("program-once word changed on a second program");

  assign word = word_q;
  assign programmed = done_q;
  assign refused = refused_q;
endmodule

// [src/cwd_pkg.sv]
// Behaviour
// - Bits 23..16 of the configuration word always read back as ones.
// - Bit 14 set enables the boundary-scan port.
// - Bit 13 set leaves program memory code protection disabled.
// - Bit 12 set allows writes to program memory.
// - Bit 11 set resets into operational mode, clear into debug mode.
// - Bit 10 clear enables retention regulator, governed by firmware enable.
// - Codes 11, 10, 01 route emulator to pin pair 1, 2, 3; 00 reserved.
// - Bit 7 set selects standard watchdog, clear selects windowed watchdog.
// - Watchdog code 11 runs the watchdog always; firmware enable ignored.
// - Watchdog code 10 lets firmware switch the watchdog on and off.
// - Watchdog code 00 stops the watchdog and disables the firmware enable.
// - Fields read back, program only once, and hold one when unprogrammed.
package cwd_pkg;
  // Word layout
  localparam logic [23:0] CW_ERASED = 24'hffffff;
  localparam logic [7:0] CW_UPPER_ONES = 8'hff;
  localparam logic [15:0] CW_LOW_ERASED = 16'hffff;
  localparam int CW_RSVD_BIT = 15;
  localparam int CW_SCAN_BIT = 14;
  localparam int CW_CP_BIT = 13;
  localparam int CW_WR_BIT = 12;
  localparam int CW_DBG_BIT = 11;
  localparam int CW_REG_BIT = 10;
  localparam int CW_PIN_LSB = 8;
  localparam int CW_WIN_BIT = 7;
  localparam int CW_WDT_LSB = 5;
  localparam int CW_PRE_BIT = 4;
  localparam int CW_POST_LSB = 0;
  // Field codes
  localparam logic [1:0] PIN_PAIR_ONE = 2'h3;
  localparam logic [1:0] PIN_PAIR_TWO = 2'h2;
  localparam logic [1:0] PIN_PAIR_THREE = 2'h1;
  localparam logic [1:0] WDT_ALWAYS = 2'h3;
  localparam logic [1:0] WDT_FIRMWARE = 2'h2;
  localparam logic [1:0] WDT_OFF = 2'h0;
  // Register byte offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_PROG = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // Control register
  localparam int CTRL_WDT_BIT = 0;
  localparam int CTRL_RET_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status register
  localparam int ST_PROGRAMMED = 0;
  localparam int ST_RSVD_ERR = 1;
  localparam int ST_PIN_ERR = 2;
  localparam int ST_WIN_ERR = 3;
  localparam int ST_WDT_RUN = 4;
  localparam int ST_RET_ON = 5;
  localparam int ST_REFUSED = 6;
  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Load sequencer
  typedef enum logic {
    CWD_LOAD = 1'b0,
    CWD_RUN = 1'b1
  } cwd_load_state_type;
endpackage

// [src/cwd_top.sv]
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module cwd_top (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Debug and protection settings
  output logic boundary_scan_port_enable,
  output logic code_protect_active,
  output logic program_write_allow,
  output logic reset_to_debug,
  // Retention regulator
  output logic retention_regulator_on,
  output logic retention_regulator_active,
  // Emulator pin routing
  output logic program_pin_pair_one,
  output logic program_pin_pair_two,
  output logic program_pin_pair_three,
  // Watchdog settings
  output logic watchdog_window_on,
  output logic watchdog_running,
  output logic firmware_watchdog_effective,
  output logic watchdog_prescale_select,
  output logic [3:0] watchdog_postscale_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] reg_addr;
  logic reg_mapped;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [15:0] store_word;
  logic store_done;
  logic store_refused;
  logic wr_prog;
  logic wr_ctrl;
  logic wr_status;
  logic rd_cfg;
  cwd_pkg::cwd_load_state_type state_q;
  logic [15:0] cfg_q;
  logic [1:0] ctrl_q;
  logic refused_q;
  logic scan_q;
  logic cp_q;
  logic wr_allow_q;
  logic dbg_q;
  logic reg_on_q;
  logic reg_act_q;
  logic [2:0] pair_q;
  logic win_q;
  logic wdt_run_q;
  logic fw_eff_q;
  logic pre_q;
  logic [3:0] post_q;
  logic [1:0] wdt_code;
  logic [1:0] pin_code;
  logic [6:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Whole word as software sees it: upper byte is not implemented
  function automatic logic [23:0] full_word(input logic [15:0] lo);
    full_word = {cwd_pkg::CW_UPPER_ONES, lo};
  endfunction

  // Watchdog run decision from the configuration code and firmware bit
  function automatic logic wdt_run(input logic [1:0] code, input logic fw);
    logic r;
    r = 1'b0;
    unique case (code)
      cwd_pkg::WDT_ALWAYS: r = 1'b1;
      cwd_pkg::WDT_FIRMWARE: r = fw;
      default: r = 1'b0;
    endcase
    wdt_run = r;
  endfunction

  // One-hot pin pair select; the reserved code routes nowhere
  function automatic logic [2:0] pair_sel(input logic [1:0] code);
    logic [2:0] s;
    s = 3'h0;
    unique case (code)
      cwd_pkg::PIN_PAIR_ONE: s = 3'h1;
      cwd_pkg::PIN_PAIR_TWO: s = 3'h2;
      cwd_pkg::PIN_PAIR_THREE: s = 3'h4;
      default: s = 3'h0;
    endcase
    pair_sel = s;
  endfunction

  assign wdt_code = cfg_q[cwd_pkg::CW_WDT_LSB +: 2];
  assign pin_code = cfg_q[cwd_pkg::CW_PIN_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and nonvolatile store

  cwd_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .reg_addr(reg_addr),
    .reg_mapped(reg_mapped),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // Store lives on the power-on reset so programmed bits survive hresetn
  cwd_nvm_store u_store (
    .hclk(hclk),
    .por_n(por_n),
    .prog(wr_prog),
    .prog_data(hwdata[15:0]),
    .word(store_word),
    .programmed(store_done),
    .refused(store_refused)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign wr_prog = reg_wr & reg_mapped & (reg_addr == cwd_pkg::REG_PROG);
  assign wr_ctrl = reg_wr & reg_mapped & (reg_addr == cwd_pkg::REG_CTRL);
  assign wr_status = reg_wr & reg_mapped & (reg_addr == cwd_pkg::REG_STATUS);
  assign rd_cfg = reg_rd & reg_mapped & (reg_addr == cwd_pkg::REG_CFG);

  // Configuration sanity flags and live state
  always_comb begin
    status = 7'h00;
    status[cwd_pkg::ST_PROGRAMMED] = store_done;
    status[cwd_pkg::ST_RSVD_ERR] = cfg_q[cwd_pkg::CW_RSVD_BIT];
    status[cwd_pkg::ST_PIN_ERR] = (pin_code == 2'h0);
    status[cwd_pkg::ST_WIN_ERR] = ~cfg_q[cwd_pkg::CW_WIN_BIT]
                                  & (wdt_code == cwd_pkg::WDT_OFF);
    status[cwd_pkg::ST_WDT_RUN] = wdt_run_q;
    status[cwd_pkg::ST_RET_ON] = reg_act_q;
    status[cwd_pkg::ST_REFUSED] = refused_q;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    reg_rdata = 32'h00000000;
    if (reg_mapped) begin
      unique case (reg_addr)
        cwd_pkg::REG_CFG: reg_rdata = {8'h00, full_word(cfg_q)};
        cwd_pkg::REG_PROG: reg_rdata = {8'h00, full_word(store_word)};
        cwd_pkg::REG_CTRL: reg_rdata = {30'h00000000, ctrl_q};
        cwd_pkg::REG_STATUS: reg_rdata = {25'h0000000, status};
        default: reg_rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  // First edge after release copies the store into the shadow word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= cwd_pkg::CWD_LOAD;
    end else begin
      state_q <= cwd_pkg::CWD_RUN;
    end
  end

  // Shadow is frozen in RUN: a program pass only counts after next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= cwd_pkg::CW_LOW_ERASED;
    end else if (state_q == cwd_pkg::CWD_LOAD) begin
      cfg_q <= store_word;
    end
  end

  cfg_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> $stable(cfg_q) && state_q == cwd_pkg::CWD_RUN)
    else $error("latched word changed after load");

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Firmware bits; watchdog enable is forced off while the code says off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= cwd_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[1:0];
      end
      if (state_q == cwd_pkg::CWD_RUN && wdt_code == cwd_pkg::WDT_OFF) begin
        ctrl_q[cwd_pkg::CTRL_WDT_BIT] <= 1'b0;
      end
    end
  end

  // Sticky refused flag; write one clears, a new refusal wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refused_q <= 1'b0;
    end else if (store_refused) begin
      refused_q <= 1'b1;
    end else if (wr_status && hwdata[cwd_pkg::ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings

  // Outputs show the erased decoding until the shadow is loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_q <= cwd_pkg::CW_ERASED[cwd_pkg::CW_SCAN_BIT];
      cp_q <= ~cwd_pkg::CW_ERASED[cwd_pkg::CW_CP_BIT];
      wr_allow_q <= cwd_pkg::CW_ERASED[cwd_pkg::CW_WR_BIT];
      dbg_q <= ~cwd_pkg::CW_ERASED[cwd_pkg::CW_DBG_BIT];
    end else if (state_q == cwd_pkg::CWD_RUN) begin
      scan_q <= cfg_q[cwd_pkg::CW_SCAN_BIT];
      cp_q <= ~cfg_q[cwd_pkg::CW_CP_BIT];
      wr_allow_q <= cfg_q[cwd_pkg::CW_WR_BIT];
      dbg_q <= ~cfg_q[cwd_pkg::CW_DBG_BIT];
    end
  end

  scan_port_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> scan_q == $past(cfg_q[cwd_pkg::CW_SCAN_BIT]))
    else $error("scan port enable does not follow bit 14");
  code_prot_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> cp_q != $past(cfg_q[cwd_pkg::CW_CP_BIT]))
    else $error("code protection not inverse of bit 13");
  write_allow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> wr_allow_q == $past(cfg_q[cwd_pkg::CW_WR_BIT]))
    else $error("write allow does not follow bit 12");
  reset_debug_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> dbg_q != $past(cfg_q[cwd_pkg::CW_DBG_BIT]))
    else $error("debug entry not inverse of bit 11");

  // Regulator enabled by a cleared bit, then gated by firmware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_on_q <= ~cwd_pkg::CW_ERASED[cwd_pkg::CW_REG_BIT];
      reg_act_q <= 1'b0;
    end else if (state_q == cwd_pkg::CWD_RUN) begin
      reg_on_q <= ~cfg_q[cwd_pkg::CW_REG_BIT];
      reg_act_q <= ~cfg_q[cwd_pkg::CW_REG_BIT] & ctrl_q[cwd_pkg::CTRL_RET_BIT];
    end
  end

  retention_reg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> reg_act_q
      == ($past(~cfg_q[cwd_pkg::CW_REG_BIT]) && $past(ctrl_q[cwd_pkg::CTRL_RET_BIT])))
    else $error("retention regulator not gated by bit 10 and firmware");

  // Emulator routing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair_q <= 3'h1;
    end else if (state_q == cwd_pkg::CWD_RUN) begin
      pair_q <= pair_sel(pin_code);
    end
  end

  pin_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN && pin_code == 2'h0 |=> pair_q == 3'h0)
    else $error("reserved pin code still routes the emulator");
  pin_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN && pin_code == cwd_pkg::PIN_PAIR_THREE
      |=> pair_q == 3'h4)
    else $error("code 01 does not select pin pair three");

  // Watchdog type, run state and prescaler fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= ~cwd_pkg::CW_ERASED[cwd_pkg::CW_WIN_BIT];
      wdt_run_q <= 1'b1;
      fw_eff_q <= 1'b0;
      pre_q <= cwd_pkg::CW_ERASED[cwd_pkg::CW_PRE_BIT];
      post_q <= cwd_pkg::CW_ERASED[cwd_pkg::CW_POST_LSB +: 4];
    end else if (state_q == cwd_pkg::CWD_RUN) begin
      win_q <= ~cfg_q[cwd_pkg::CW_WIN_BIT];
      wdt_run_q <= wdt_run(wdt_code, ctrl_q[cwd_pkg::CTRL_WDT_BIT]);
      fw_eff_q <= (wdt_code == cwd_pkg::WDT_FIRMWARE);
      pre_q <= cfg_q[cwd_pkg::CW_PRE_BIT];
      post_q <= cfg_q[cwd_pkg::CW_POST_LSB +: 4];
    end
  end

  wdt_window_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN |=> win_q == !$past(cfg_q[cwd_pkg::CW_WIN_BIT]))
    else $error("window select not inverse of bit 7");
  wdt_always_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN && wdt_code == cwd_pkg::WDT_ALWAYS
      |=> wdt_run_q && !fw_eff_q)
    else $error("watchdog not forced on by code 11");
  wdt_firmware_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN && wdt_code == cwd_pkg::WDT_FIRMWARE
      |=> wdt_run_q == $past(ctrl_q[cwd_pkg::CTRL_WDT_BIT]) && fw_eff_q)
    else $error("watchdog not under firmware with code 10");
  wdt_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == cwd_pkg::CWD_RUN && wdt_code == cwd_pkg::WDT_OFF
      |=> ##1 !wdt_run_q && !ctrl_q[cwd_pkg::CTRL_WDT_BIT])
    else $error("watchdog or firmware bit alive with code 00");
  upper_ones_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_cfg |=> hrdata[23:16] == 8'hff && hreadyout)
    else $error("upper configuration byte did not read as ones");

  ////////////////////////////////////////////////////////////////////////////
  // Output drive

  assign boundary_scan_port_enable = scan_q;
  assign code_protect_active = cp_q;
  assign program_write_allow = wr_allow_q;
  assign reset_to_debug = dbg_q;
  assign retention_regulator_on = reg_on_q;
  assign retention_regulator_active = reg_act_q;
  assign program_pin_pair_one = pair_q[0];
  assign program_pin_pair_two = pair_q[1];
  assign program_pin_pair_three = pair_q[2];
  assign watchdog_window_on = win_q;
  assign watchdog_running = wdt_run_q;
  assign firmware_watchdog_effective = fw_eff_q;
  assign watchdog_prescale_select = pre_q;
  assign watchdog_postscale_select = post_q;
endmodule

// [tb/config_word_decoder_tb.sv]
`timescale 1ns/100ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module config_word_decoder_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, boundary_scan_port_enable, code_protect_active;
  logic program_write_allow, reset_to_debug, retention_regulator_on;
  logic retention_regulator_active, program_pin_pair_one, program_pin_pair_two;
  logic program_pin_pair_three, watchdog_window_on, watchdog_running;
  logic firmware_watchdog_effective, watchdog_prescale_select;
  logic [3:0] watchdog_postscale_select;
  logic [31:0] hrdata;
  logic [15:0] raw = 16'hffff;
  logic [15:0] pw;
  logic rd_dp = 1'b0;
  logic [31:0] q[$];
  logic [31:0] rd_exp;
  logic [1:0] c;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 52782;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz
  always #2 hclk = ~hclk;
  cwd_programmer prg (.raw(raw), .word(pw));
  // One slave only, so its ready is the bus ready
  cwd_top uut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .boundary_scan_port_enable,
    .code_protect_active, .program_write_allow, .reset_to_debug, .retention_regulator_on,
    .retention_regulator_active, .program_pin_pair_one, .program_pin_pair_two,
    .program_pin_pair_three, .watchdog_window_on, .watchdog_running,
    .firmware_watchdog_effective, .watchdog_prescale_select, .watchdog_postscale_select);
  wire [14:0] outs = {boundary_scan_port_enable, code_protect_active, program_write_allow,
    reset_to_debug, retention_regulator_on, program_pin_pair_one, program_pin_pair_two,
    program_pin_pair_three, watchdog_window_on, firmware_watchdog_effective,
    watchdog_prescale_select, watchdog_postscale_select};
  ////////////////////////////////////////////////////////////////////////////////
  // Expected decoding of a stored word
  function automatic logic [14:0] dec(input logic [15:0] w);
    return {w[14], ~w[13], w[12], ~w[11], ~w[10], w[9:8] == 2'h3, w[9:8] == 2'h2,
      w[9:8] == 2'h1, ~w[7], w[6:5] == 2'h2, w[4], w[3:0]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for ready sampled high at a rising edge
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
      if (k > 50) begin
        n_errors++;
        wrap_up;
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= ~w;
    wt;
    rd_dp <= 1'b0;
  endtask
  // Reads note their expectation; the watcher settles it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic rst(input logic p);
    hresetn <= 1'b0;
    if (p) begin
      por_n <= 1'b0;
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Read data watcher; the note is popped once so a mismatch print cannot eat the next one
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) begin
      rd_exp = q.pop_front();
      `CHK("hrdata", rd_exp, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst(1'b1);
    `CHK("erased", dec(16'hffff), outs)
    `CHK("erased_run", 1'b1, watchdog_running)
    rd(cwd_pkg::REG_CFG, 32'h00ffffff);
    rd(8'h40, 32'h0);
    // One pass per pin code and watchdog code
    for (int i = 0; i < 4; i++) begin
      raw = 16'($random(seed));
      raw[9:8] = 2'(i);
      raw[6:5] = 2'(i);
      // Code 00 is only legal with the standard watchdog
      if (i == 0) begin
        raw[7] = 1'b1;
      end
      rst(1'b1);
      xfer(1'b1, cwd_pkg::REG_PROG, {16'h0, pw});
      xfer(1'b1, cwd_pkg::REG_PROG, 32'h0);
      rd(cwd_pkg::REG_PROG, {16'h00ff, pw});
      rd(cwd_pkg::REG_CFG, 32'h00ffffff);
      // Refused second pass is sticky until software writes one to clear it
      rd(cwd_pkg::REG_STATUS, 32'h00000053);
      xfer(1'b1, cwd_pkg::REG_STATUS, 32'h00000040);
      rd(cwd_pkg::REG_STATUS, 32'h00000013);
      `CHK("held", dec(16'hffff), outs)
      rst(1'b0);
      `CHK("decode", dec(pw), outs)
      rd(cwd_pkg::REG_CFG, {16'h00ff, pw});
      c = 2'($random(seed));
      xfer(1'b1, cwd_pkg::REG_CTRL, {30'h0, c});
      repeat (2) @(posedge hclk);
      `CHK("ret_act", ~pw[10] & c[1], retention_regulator_active)
      `CHK("wdt_run", i == 3 || (i == 2 && c[0]), watchdog_running)
      rd(cwd_pkg::REG_CTRL, {30'h0, c[1], c[0] & (i != 0)});
    end
    wrap_up;
  end
endmodule

// [tb/cwd_programmer.sv]
`timescale 1ns/100ps
module cwd_programmer (
  // Word the bench would like to burn
  input wire logic [15:0] raw,
  // Word as the programmer really burns it
  output logic [15:0] word
);
  // Legalise the request the way a careful programmer would
  always_comb begin
    word = raw;
    word[15] = 1'b0;
    // Windowed watchdog with code 00 is illegal, so fall back to firmware control
    if (!word[7] && word[6:5] == 2'h0) begin
      word[6:5] = 2'h2;
    end
  end
endmodule
